// ==== core/ilg_io_lock_capture.v ====
// i/o line configuration with peripheral locks, parallel capture and write guard
// apb slave on pclk; capture pins and lock inputs come from outside and are
// synchronised here; dma end/full status inputs are on pclk
`include "ilg_defines.vh"
`default_nettype none
module ilg_io_lock_capture (
  input  wire        pclk,             // apb clock, 200 mhz
  input  wire        presetn,          // async reset, active low
  input  wire        psel,             // apb select
  input  wire        penable,          // apb access phase
  input  wire        pwrite,           // apb direction
  input  wire [11:0] paddr,            // apb byte address
  input  wire [31:0] pwdata,           // apb write data
  output reg  [31:0] prdata,           // apb read data
  output reg         pready,           // apb ready
  output reg         pslverr,          // apb error, unmapped address
  input  wire [31:0] line_lock_req,    // per-line lock request from owners
  input  wire        capture_clock_in, // sensor clock pin
  input  wire [7:0]  capture_data_in,  // sensor data pins
  input  wire        capture_qualifier_a, // sensor data enable 1
  input  wire        capture_qualifier_b, // sensor data enable 2
  input  wire        dma_rx_end_in,    // dma end of receive, pclk level
  input  wire        dma_rx_full_in,   // dma buffer full, pclk level
  output reg         dma_rx_req,       // pulse: new word in holding register
  output reg         capture_pins_input, // forces capture lines to inputs
  output reg  [31:0] line_pio_ctrl,    // line driven by controller
  output reg  [31:0] line_out_en,      // output enable per line
  output reg  [31:0] line_filter_en,   // glitch filter enable per line
  output reg  [31:0] line_open_drain,  // multi-driver enable per line
  output reg  [31:0] line_pullup_en,   // pull-up enable per line
  output reg  [31:0] line_pulldown_en, // pull-down enable per line
  output reg  [31:0] line_sel_low,     // peripheral select bit 0
  output reg  [31:0] line_sel_high,    // peripheral select bit 1
  output reg  [31:0] line_out_write_en, // output write enable per line
  output reg  [31:0] line_schmitt_off, // 1 disables schmitt trigger
  output reg         irq               // capture interrupt, high active
);

  reg  [31:0] lock_r;
  reg  [31:0] cap_mode_r;
  reg  [3:0]  irq_mask_r;
  reg         rdy_r;
  reg         ovr_r;
  reg  [31:0] hold_r;
  reg  [31:0] asm_r;
  reg  [1:0]  cnt_r;
  reg         parity_r;
  reg         wg_en_r;
  reg         wg_flag_r;
  reg  [11:0] wg_src_r;
  reg  [31:0] lock_s1_r;
  reg  [31:0] lock_s2_r;
  reg  [10:0] cap_s1_r;
  reg  [10:0] cap_s2_r;
  reg         cclk_d_r;

  wire        setup    = psel & ~penable;
  wire        rd_setup = setup & ~pwrite;
  wire        wr_acc   = psel & penable & pwrite & pready;

  function is_guarded;
    input [11:0] a;
    begin
      case (a)
        `ILG_LINE_EN, `ILG_LINE_DIS, `ILG_OUT_EN, `ILG_OUT_DIS,
        `ILG_FILT_EN, `ILG_FILT_DIS, `ILG_OD_EN, `ILG_OD_DIS,
        `ILG_PU_DIS, `ILG_PU_EN, `ILG_SEL_LOW, `ILG_SEL_HIGH,
        `ILG_OW_EN, `ILG_OW_DIS, `ILG_PD_DIS, `ILG_PD_EN,
        `ILG_CAP_MODE: is_guarded = 1'b1;
        default:       is_guarded = 1'b0;
      endcase
    end
  endfunction

  function is_mapped;
    input [11:0] a;
    begin
      case (a)
        `ILG_LINE_STAT, `ILG_OUT_STAT, `ILG_FILT_STAT, `ILG_OD_STAT,
        `ILG_PU_STAT, `ILG_PD_STAT, `ILG_OW_STAT, `ILG_LOCK_STAT,
        `ILG_WG_MODE, `ILG_WG_STAT, `ILG_SCHMITT, `ILG_CAP_IRQ_EN,
        `ILG_CAP_IRQ_DIS, `ILG_CAP_IRQ_MSK, `ILG_CAP_IRQ_ST,
        `ILG_CAP_HOLD: is_mapped = 1'b1;
        default:       is_mapped = is_guarded(a);
      endcase
    end
  endfunction

  // locked bits keep their old value
  function [31:0] keep_locked;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] lk;
    begin
      keep_locked = (old_v & lk) | (new_v & ~lk);
    end
  endfunction

  wire blocked  = wr_acc & wg_en_r & is_guarded(paddr);
  wire wr_ok    = wr_acc & ~blocked;
  wire cap_en   = cap_mode_r[`ILG_CM_EN];

  // lock requests cross in from other logic; two flops first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s1_r <= `ILG_RST_ZERO;
      lock_s2_r <= `ILG_RST_ZERO;
      lock_r    <= `ILG_RST_ZERO;
    end else begin
      lock_s1_r <= line_lock_req;
      lock_s2_r <= lock_s1_r;
      lock_r    <= lock_r | lock_s2_r;
    end
  end

  // line configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_pio_ctrl     <= `ILG_RST_LINE;
      line_out_en       <= `ILG_RST_ZERO;
      line_filter_en    <= `ILG_RST_ZERO;
      line_open_drain   <= `ILG_RST_ZERO;
      line_pullup_en    <= `ILG_RST_PU;
      line_pulldown_en  <= `ILG_RST_PD;
      line_sel_low      <= `ILG_RST_ZERO;
      line_sel_high     <= `ILG_RST_ZERO;
      line_out_write_en <= `ILG_RST_ZERO;
      line_schmitt_off  <= `ILG_RST_ZERO;
    end else if (wr_ok) begin
      case (paddr)
        `ILG_LINE_EN:  line_pio_ctrl <= keep_locked(line_pio_ctrl,
                         line_pio_ctrl | pwdata, lock_r);
        `ILG_LINE_DIS: line_pio_ctrl <= keep_locked(line_pio_ctrl,
                         line_pio_ctrl & ~pwdata, lock_r);
        `ILG_OUT_EN:   line_out_en <= line_out_en | pwdata;
        `ILG_OUT_DIS:  line_out_en <= line_out_en & ~pwdata;
        `ILG_FILT_EN:  line_filter_en <= line_filter_en | pwdata;
        `ILG_FILT_DIS: line_filter_en <= line_filter_en & ~pwdata;
        `ILG_OD_EN:    line_open_drain <= keep_locked(line_open_drain,
                         line_open_drain | pwdata, lock_r);
        `ILG_OD_DIS:   line_open_drain <= keep_locked(line_open_drain,
                         line_open_drain & ~pwdata, lock_r);
        `ILG_PU_DIS:   line_pullup_en <= keep_locked(line_pullup_en,
                         line_pullup_en & ~pwdata, lock_r);
        `ILG_PU_EN:    line_pullup_en <= keep_locked(line_pullup_en,
                         line_pullup_en | pwdata, lock_r);
        `ILG_SEL_LOW:  line_sel_low <= keep_locked(line_sel_low,
                         pwdata, lock_r);
        `ILG_SEL_HIGH: line_sel_high <= keep_locked(line_sel_high,
                         pwdata, lock_r);
        `ILG_PD_DIS:   line_pulldown_en <= line_pulldown_en & ~pwdata;
        `ILG_PD_EN:    line_pulldown_en <= line_pulldown_en | pwdata;
        `ILG_OW_EN:    line_out_write_en <= line_out_write_en | pwdata;
        `ILG_OW_DIS:   line_out_write_en <= line_out_write_en & ~pwdata;
        `ILG_SCHMITT:  line_schmitt_off <= pwdata;
        default: begin
        end
      endcase
    end
  end

  // capture mode, interrupt mask, write guard mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_mode_r <= `ILG_RST_ZERO;
      irq_mask_r <= 4'h0;
      wg_en_r    <= 1'b0;
    end else if (wr_ok) begin
      case (paddr)
        `ILG_CAP_MODE:    cap_mode_r <= pwdata & `ILG_CM_MASK;
        `ILG_CAP_IRQ_EN:  irq_mask_r <= irq_mask_r | pwdata[3:0];
        `ILG_CAP_IRQ_DIS: irq_mask_r <= irq_mask_r & ~pwdata[3:0];
        `ILG_WG_MODE:     wg_en_r <= pwdata[`ILG_WG_EN];
        default: begin
        end
      endcase
    end
  end

  // violation flag: a new violation wins over the clearing read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wg_flag_r <= 1'b0;
      wg_src_r  <= 12'h000;
    end else if (blocked) begin
      wg_flag_r <= 1'b1;
      wg_src_r  <= paddr;
    end else if (rd_setup && paddr == `ILG_WG_STAT) begin
      wg_flag_r <= 1'b0;
    end
  end

  // capture pins: every pin through two flops before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_s1_r <= 11'h000;
      cap_s2_r <= 11'h000;
      cclk_d_r <= 1'b0;
    end else begin
      cap_s1_r <= {capture_clock_in, capture_qualifier_b, capture_qualifier_a,
                   capture_data_in};
      cap_s2_r <= cap_s1_r;
      cclk_d_r <= cap_s2_r[10];
    end
  end

  // data and qualifiers are stable around the sensor edge since pclk > 2x its rate
  wire       cclk_rise = cap_s2_r[10] & ~cclk_d_r;
  wire [7:0] sample    = cap_s2_r[7:0];
  wire       qual_ok   = cap_mode_r[`ILG_CM_IGN] |
                         (cap_s2_r[8] & cap_s2_r[9]);
  wire       qualifies = cap_en & cclk_rise & qual_ok;
  wire       keep      = ~cap_mode_r[`ILG_CM_HALF] |
                         (parity_r == cap_mode_r[`ILG_CM_FIRST]);
  wire       accept    = qualifies & keep;
  wire [1:0] wid       = cap_mode_r[`ILG_CM_WID_HI:`ILG_CM_WID_LO];
  wire [1:0] last_cnt  = (wid == `ILG_WID_BYTE) ? 2'h0 :
                         (wid == `ILG_WID_HALF) ? 2'h1 : 2'h3;
  wire       word_done = accept & (cnt_r == last_cnt);
  reg  [31:0] asm_nxt;

  always @* begin
    asm_nxt = asm_r;
    case (cnt_r)
      2'h0:    asm_nxt = {24'h000000, sample};
      2'h1:    asm_nxt[15:8]  = sample;
      2'h2:    asm_nxt[23:16] = sample;
      2'h3:    asm_nxt[31:24] = sample;
      default: asm_nxt = asm_r;
    endcase
  end

  // sample index and byte assembly restart whenever capture is off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_r <= 1'b0;
      cnt_r    <= 2'h0;
      asm_r    <= `ILG_RST_ZERO;
      hold_r   <= `ILG_RST_ZERO;
    end else if (!cap_en) begin
      parity_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (qualifies)
        parity_r <= ~parity_r;
      if (accept) begin
        asm_r <= asm_nxt;
        cnt_r <= word_done ? 2'h0 : cnt_r + 2'h1;
      end
      if (word_done)
        hold_r <= asm_nxt;
    end
  end

  // ready and overrun: hardware set wins over the clearing read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      if (word_done)
        rdy_r <= 1'b1;
      else if (rd_setup && paddr == `ILG_CAP_HOLD)
        rdy_r <= 1'b0;
      if (word_done && rdy_r)
        ovr_r <= 1'b1;
      else if (rd_setup && paddr == `ILG_CAP_IRQ_ST)
        ovr_r <= 1'b0;
    end
  end

  wire [3:0] irq_stat = {dma_rx_full_in, dma_rx_end_in, ovr_r, rdy_r};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq                <= 1'b0;
      dma_rx_req         <= 1'b0;
      capture_pins_input <= 1'b0;
    end else begin
      irq                <= |(irq_stat & irq_mask_r);
      dma_rx_req         <= word_done;
      capture_pins_input <= cap_en;
    end
  end

  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h00000000;
    case (paddr)
      `ILG_LINE_STAT:   rd_nxt = line_pio_ctrl;
      `ILG_OUT_STAT:    rd_nxt = line_out_en;
      `ILG_FILT_STAT:   rd_nxt = line_filter_en;
      `ILG_OD_STAT:     rd_nxt = line_open_drain;
      `ILG_PU_STAT:     rd_nxt = line_pullup_en;
      `ILG_PD_STAT:     rd_nxt = line_pulldown_en;
      `ILG_SEL_LOW:     rd_nxt = line_sel_low;
      `ILG_SEL_HIGH:    rd_nxt = line_sel_high;
      `ILG_OW_STAT:     rd_nxt = line_out_write_en;
      `ILG_LOCK_STAT:   rd_nxt = lock_r;
      `ILG_WG_MODE:     rd_nxt = {31'h00000000, wg_en_r};
      `ILG_WG_STAT:     rd_nxt = {12'h000, wg_src_r, 7'h00, wg_flag_r};
      `ILG_SCHMITT:     rd_nxt = line_schmitt_off;
      `ILG_CAP_MODE:    rd_nxt = cap_mode_r;
      `ILG_CAP_IRQ_MSK: rd_nxt = {28'h0000000, irq_mask_r};
      `ILG_CAP_IRQ_ST:  rd_nxt = {28'h0000000, irq_stat};
      `ILG_CAP_HOLD:    rd_nxt = hold_r;
      default:          rd_nxt = 32'h00000000;
    endcase
  end

  // one wait-free access: answer latched in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h00000000 : rd_nxt;
      pready  <= 1'b1;
      pslverr <= ~is_mapped(paddr);
    end else begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // ilg_io_lock_capture
`default_nettype wire

// ==== include/ilg_defines.vh ====
// register map, field positions, reset values and encodings of the i/o lock,
// parallel capture and write guard block
// assumes 32-bit apb data and one aligned word per register
//
// Operation
// - a peripheral lock input marks its i/o line locked
// - locked line bits are ignored in line enable, open-drain, pull-up and select writes
// - read-only lock status register shows one lock bit per line
// - locks persist against software; only controller reset releases them
// - per-input schmitt trigger setting, every trigger active after reset
// - capture enable forces capture clock, data and qualifier lines to inputs
// - data sampled on capture clock rising edge, resynchronised to pclk
// - wider sizes concatenate byte samples, store word, set ready flag
// - block feeds dma receive channel, shows its end and full flags
// - qualifiers honoured: sample only when both qualifiers are high
// - ignore-qualifiers set: sample on every capture clock rising edge
// - half sampling keeps every second qualifying sample, otherwise all
// - first-sample parity zero keeps even indices, one keeps odd
// - word stored before previous read overwrites it and sets overrun
// - reading the capture status register clears overrun
// - ready, overrun, dma end and full raise interrupt through a mask
// - write guard enabled blocks writes to the protected configuration registers
// - blocked write sets violation flag and source; status read clears flag
`ifndef ILG_DEFINES_VH
`define ILG_DEFINES_VH

`define ILG_LINE_EN     12'h000
`define ILG_LINE_DIS    12'h004
`define ILG_LINE_STAT   12'h008
`define ILG_OUT_EN      12'h010
`define ILG_OUT_DIS     12'h014
`define ILG_OUT_STAT    12'h018
`define ILG_FILT_EN     12'h020
`define ILG_FILT_DIS    12'h024
`define ILG_FILT_STAT   12'h028
`define ILG_OD_EN       12'h050
`define ILG_OD_DIS      12'h054
`define ILG_OD_STAT     12'h058
`define ILG_PU_DIS      12'h060
`define ILG_PU_EN       12'h064
`define ILG_PU_STAT     12'h068
`define ILG_SEL_LOW     12'h070
`define ILG_SEL_HIGH    12'h074
`define ILG_PD_DIS      12'h090
`define ILG_PD_EN       12'h094
`define ILG_PD_STAT     12'h098
`define ILG_OW_EN       12'h0a0
`define ILG_OW_DIS      12'h0a4
`define ILG_OW_STAT     12'h0a8
`define ILG_LOCK_STAT   12'h0e0
`define ILG_WG_MODE     12'h0e4
`define ILG_WG_STAT     12'h0e8
`define ILG_SCHMITT     12'h100
`define ILG_CAP_MODE    12'h150
`define ILG_CAP_IRQ_EN  12'h154
`define ILG_CAP_IRQ_DIS 12'h158
`define ILG_CAP_IRQ_MSK 12'h15c
`define ILG_CAP_IRQ_ST  12'h160
`define ILG_CAP_HOLD    12'h164

`define ILG_RST_LINE    32'hffffffff
`define ILG_RST_PU      32'hffffffff
`define ILG_RST_PD      32'h00000000
`define ILG_RST_ZERO    32'h00000000

// capture mode fields
`define ILG_CM_EN       0
`define ILG_CM_WID_LO   4
`define ILG_CM_WID_HI   5
`define ILG_CM_IGN      9
`define ILG_CM_HALF     10
`define ILG_CM_FIRST    11
`define ILG_CM_MASK     32'h00000e31
`define ILG_WID_BYTE    2'h0
`define ILG_WID_HALF    2'h1
`define ILG_WID_WORD    2'h2

// capture status / mask bits
`define ILG_IS_RDY      0
`define ILG_IS_OVR      1
`define ILG_IS_END      2
`define ILG_IS_FULL     3

// write guard fields
`define ILG_WG_EN       0
`define ILG_WG_FLAG     0
`define ILG_WG_SRC_LO   8
`define ILG_WG_SRC_HI   19

`endif

// ==== test/ilg_props.sv ====
// concurrent checks on the ports of the lock, capture and guard block
// assumes zero wait state apb and the offsets of the shared defines
`include "ilg_defines.vh"
`default_nettype none
module ilg_props (
  input wire logic        pclk,               // apb clock
  input wire logic        presetn,            // async reset, low
  input wire logic        psel,               // select
  input wire logic        penable,            // access phase
  input wire logic        pwrite,             // direction
  input wire logic [11:0] paddr,              // byte address
  input wire logic [31:0] pwdata,             // write data
  input wire logic [31:0] prdata,             // read data
  input wire logic        pready,             // ready
  input wire logic        pslverr,            // error
  input wire logic [31:0] line_lock_req,      // lock requests
  input wire logic        dma_rx_end_in,      // dma end level
  input wire logic        dma_rx_req,         // word pulse
  input wire logic        capture_pins_input, // capture lines forced in
  input wire logic [31:0] line_pio_ctrl,      // line control
  input wire logic [31:0] line_sel_high,      // select bit 1
  input wire logic        irq                 // interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] lk_d1, lk_d2, lk, lk_old;
  logic        guard_r;
  logic [3:0]  msk;
  wire         acc_wr = psel & penable & pwrite & pready;
  wire         setup_rd = psel & ~penable & ~pwrite;
  // lock copy trails the design by an edge so the check never races it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_d1   <= 32'h0;
      lk_d2   <= 32'h0;
      lk      <= 32'h0;
      lk_old  <= 32'h0;
      guard_r <= 1'b0;
      msk     <= 4'h0;
    end else begin
      lk_d1  <= line_lock_req;
      lk_d2  <= lk_d1;
      lk     <= lk | lk_d2;
      lk_old <= lk;
      if (acc_wr && paddr == `ILG_WG_MODE) guard_r <= pwdata[0];
      if (acc_wr && paddr == `ILG_CAP_IRQ_EN) msk <= msk | pwdata[3:0];
      else if (acc_wr && paddr == `ILG_CAP_IRQ_DIS) msk <= msk & ~pwdata[3:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_unmapped_err: assert property (psel && !penable && paddr == 12'h00c |=> pslverr)
    else $error("unmapped access without error");
  a_lock_hold: assert property (
    (((line_pio_ctrl ^ $past(line_pio_ctrl)) | (line_sel_high ^ $past(line_sel_high)))
      & lk_old) == 32'h0) else $error("locked line bit changed");
  a_lock_read: assert property (
    setup_rd && paddr == `ILG_LOCK_STAT |=> (prdata & $past(lk_old)) == $past(lk_old))
    else $error("lock status misses a locked line");
  a_mode_pins: assert property (
    acc_wr && paddr == `ILG_CAP_MODE && !guard_r
      |-> ##2 capture_pins_input == $past(pwdata[0], 2)) else $error("pins not forced");
  a_mode_guard: assert property (
    acc_wr && paddr == `ILG_CAP_MODE && guard_r
      |-> ##2 capture_pins_input == $past(capture_pins_input, 2))
    else $error("guarded mode write took effect");
  a_irq_end: assert property (dma_rx_end_in && msk[2] |-> ##[1:3] irq)
    else $error("dma end did not raise irq");
  a_irq_masked: assert property ((msk == 4'h0) [*4] |-> !irq)
    else $error("irq with empty mask");
  a_req_pulse: assert property (dma_rx_req |=> !dma_rx_req)
    else $error("word pulse longer than a cycle");
  a_idle_quiet: assert property (!capture_pins_input [*4] |-> !dma_rx_req)
    else $error("word while capture off");
  cover property (dma_rx_req);
  cover property (irq);
  cover property (acc_wr && guard_r && paddr == `ILG_OUT_DIS);
endmodule // ilg_props
bind ilg_io_lock_capture ilg_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .line_lock_req(line_lock_req), .dma_rx_end_in(dma_rx_end_in), .dma_rx_req(dma_rx_req),
  .capture_pins_input(capture_pins_input), .line_pio_ctrl(line_pio_ctrl),
  .line_sel_high(line_sel_high), .irq(irq)
);
`default_nettype wire

// ==== test/ilg_sensor_model.sv ====
// behavioural image sensor: clock, byte data and two qualifiers
// assumes the bench calls send per sample and release_bus after a frame
`default_nettype none
module ilg_sensor_model (
  output logic       capture_clock_in,    // still between frames
  output logic [7:0] capture_data_in,     // byte data
  output logic       capture_qualifier_a, // data enable one
  output logic       capture_qualifier_b  // data enable two
);
  timeunit 1ns;
  timeprecision 100ps;
  // 160 ns period keeps pclk above twice the sensor rate
  localparam real half_ns = 80.0;
  initial begin
    capture_clock_in = 1'b0;
    capture_data_in = 8'h00;
    capture_qualifier_a = 1'b0;
    capture_qualifier_b = 1'b0;
  end
  // data and qualifiers settle a half period before the rising edge
  task automatic send(input logic [7:0] d, input logic a, input logic b);
    #1.3;
    capture_data_in = d;
    capture_qualifier_a = a;
    capture_qualifier_b = b;
    #(half_ns);
    capture_clock_in = 1'b1;
    #(half_ns - 1.3);
    capture_clock_in = 1'b0;
  endtask
  // released lines show the inverse, never a stale copy
  task automatic release_bus();
    capture_data_in = ~capture_data_in;
    capture_qualifier_a = ~capture_qualifier_a;
    capture_qualifier_b = ~capture_qualifier_b;
  endtask
endmodule // ilg_sensor_model
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the lock, capture and write guard block
// assumes the sensor model on the capture pins and apb on pclk
`include "ilg_defines.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] smp = 64'h8877665544332211;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, lock_req = 32'h0;
  logic        end_in = 1'b0, full_in = 1'b0;
  wire  [31:0] prdata, pio, oe, od, pu, sl, sh, fe, pd, ow, so;
  wire  [7:0]  cdat;
  wire         pready, pslverr, rx_req, pins_in, irq, cclk, qa, qb;
  int          miscompares = 0, n_checks = 0, n_req = 0;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (rx_req === 1'b1) n_req <= n_req + 1;
  ilg_io_lock_capture dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_lock_req(lock_req), .capture_clock_in(cclk), .capture_data_in(cdat),
    .capture_qualifier_a(qa), .capture_qualifier_b(qb), .dma_rx_end_in(end_in),
    .dma_rx_full_in(full_in), .dma_rx_req(rx_req), .capture_pins_input(pins_in),
    .line_pio_ctrl(pio), .line_out_en(oe), .line_filter_en(fe), .line_open_drain(od),
    .line_pullup_en(pu), .line_pulldown_en(pd), .line_sel_low(sl), .line_sel_high(sh),
    .line_out_write_en(ow), .line_schmitt_off(so), .irq(irq)
  );
  ilg_sensor_model snsr (
    .capture_clock_in(cclk), .capture_data_in(cdat),
    .capture_qualifier_a(qa), .capture_qualifier_b(qb)
  );
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up(input bit hung);
    if (hung) miscompares++;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 32);
    if (pready !== 1'b1) wrap_up(1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(a, 1'b1, d, q, e);
    @(negedge pclk);
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    xfer(a, 1'b0, 32'h0, q, e);
    check(nm, q, exp);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd_chk("line_stat", `ILG_LINE_STAT, `ILG_RST_LINE);
    rd_chk("pu_stat", `ILG_PU_STAT, `ILG_RST_PU);
    rd_chk("schmitt", `ILG_SCHMITT, 32'h00000000);
    rd_chk("lock_stat", `ILG_LOCK_STAT, 32'h00000000);
    wr(`ILG_SCHMITT, 32'h0000000f);
    rd_chk("schmitt_wr", `ILG_SCHMITT, 32'h0000000f);
    check("schmitt_out", so, 32'h0000000f);
    check("fe_pd_ow", fe | pd | ow, 32'h0);
    xfer(12'h00c, 1'b0, 32'h0, q, e);
    check("unmapped", {31'h0, e}, 32'h00000001);
  endtask
  task automatic t_lock();
    @(posedge pclk);
    lock_req <= 32'h00000005;
    repeat (6) @(posedge pclk);
    wr(`ILG_LINE_DIS, 32'hffffffff);
    wr(`ILG_OD_EN, 32'hffffffff);
    wr(`ILG_PU_DIS, 32'hffffffff);
    wr(`ILG_SEL_LOW, 32'hffffffff);
    wr(`ILG_SEL_HIGH, 32'hffffffff);
    wr(`ILG_OUT_EN, 32'hffffffff);
    check("pio", pio, 32'h00000005);
    check("od", od, 32'hfffffffa);
    check("pu", pu, 32'h00000005);
    check("sl", sl, 32'hfffffffa);
    check("sh", sh, 32'hfffffffa);
    check("oe", oe, 32'hffffffff);
    @(posedge pclk);
    lock_req <= 32'h0;
    wr(`ILG_LOCK_STAT, 32'h0);
    wr(`ILG_LINE_EN, 32'hffffffff);
    wr(`ILG_LINE_DIS, 32'hffffffff);
    check("pio_kept", pio, 32'h00000005);
    rd_chk("lock_kept", `ILG_LOCK_STAT, 32'h00000005);
  endtask
  task automatic t_irq();
    int n;
    wr(`ILG_CAP_IRQ_EN, 32'h00000005);
    rd_chk("mask", `ILG_CAP_IRQ_MSK, 32'h00000005);
    @(posedge pclk);
    end_in <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    check("irq_end", {31'h0, irq}, 32'h1);
    rd_chk("st_end", `ILG_CAP_IRQ_ST, 32'h00000004);
    wr(`ILG_CAP_IRQ_DIS, 32'h00000004);
    @(posedge pclk);
    full_in <= 1'b1;
    repeat (3) @(negedge pclk);
    check("irq_off", {31'h0, irq}, 32'h0);
    rd_chk("st_full", `ILG_CAP_IRQ_ST, 32'h0000000c);
    end_in <= 1'b0;
    full_in <= 1'b0;
  endtask
  task automatic t_cap(input logic [1:0] wid, input logic ign, half, first,
                       input int n, input logic [7:0] qm);
    logic [31:0] w, hold, st, cfg;
    logic        e;
    int          k, idx, nw, nb, t;
    cfg = {20'h0, first, half, ign, 3'h0, wid, 4'h0};
    nb = (wid == `ILG_WID_BYTE) ? 1 : (wid == `ILG_WID_HALF) ? 2 : 4;
    w = 32'h0;
    hold = 32'h0;
    k = 0;
    idx = 0;
    nw = 0;
    for (int i = 0; i < n; i++) begin
      if (ign || qm[i]) begin
        if (!half || idx[0] == first) begin
          w[8*k +: 8] = smp[8*i +: 8];
          k++;
          if (k == nb) begin
            hold = w;
            k = 0;
            nw++;
          end
        end
        idx++;
      end
    end
    wr(`ILG_CAP_MODE, cfg);
    wr(`ILG_CAP_MODE, cfg | 32'h1);
    @(negedge pclk);
    check("pins_in", {31'h0, pins_in}, 32'h1);
    @(posedge pclk);
    k = n_req;
    for (int i = 0; i < n; i++)
      snsr.send(smp[8*i +: 8], qm[i] | i[0], qm[i] | ~i[0]);
    snsr.release_bus();
    t = 0;
    do begin
      xfer(`ILG_CAP_IRQ_ST, 1'b0, 32'h0, st, e);
      t++;
    end while (st[0] !== 1'b1 && t < 64);
    if (st[0] !== 1'b1) wrap_up(1'b1);
    check("rdy_ovr", st & 32'h3, {30'h0, nw > 1, 1'b1});
    rd_chk("hold", `ILG_CAP_HOLD, hold);
    check("dma_req", n_req - k, nw);
    rd_chk("st_clr", `ILG_CAP_IRQ_ST, 32'h0);
    wr(`ILG_CAP_MODE, cfg);
  endtask
  task automatic t_guard();
    logic [31:0] q;
    logic        e;
    wr(`ILG_WG_MODE, 32'h00000001);
    wr(`ILG_OUT_DIS, 32'hffffffff);
    check("oe_kept", oe, 32'hffffffff);
    rd_chk("wg_src", `ILG_WG_STAT, 32'h00001401);
    wr(`ILG_CAP_MODE, 32'h00000001);
    repeat (2) @(negedge pclk);
    check("pins_kept", {31'h0, pins_in}, 32'h0);
    rd_chk("wg_src2", `ILG_WG_STAT, 32'h00015001);
    xfer(`ILG_WG_STAT, 1'b0, 32'h0, q, e);
    check("wg_clr", q & 32'h1, 32'h0);
    wr(`ILG_WG_MODE, 32'h0);
    wr(`ILG_OUT_DIS, 32'hffffffff);
    check("oe_free", oe, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_lock();
    t_irq();
    t_cap(`ILG_WID_BYTE, 1'b0, 1'b0, 1'b0, 4, 8'h02);
    t_cap(`ILG_WID_HALF, 1'b0, 1'b1, 1'b1, 6, 8'h3b);
    t_cap(`ILG_WID_WORD, 1'b1, 1'b1, 1'b0, 8, 8'h00);
    t_cap(`ILG_WID_BYTE, 1'b1, 1'b0, 1'b0, 2, 8'h00);
    t_guard();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("lock_rst", `ILG_LOCK_STAT, 32'h0);
    wrap_up(1'b0);
  end
endmodule // tb_top
`default_nettype wire
